// *** include/rmsel_pkg.sv ***
// Constants, field layout and carrier types of the remappable input select bank.
// Behaviour
// - Selector code zero ties the peripheral input low to ground.
// - Selector code one feeds the peripheral input from comparator one.
// - Input-only selectors: code 124 routes remap input pin 124, the top choice.
// - Encoder B phase A and B selectors reach code 127, remap pin 127.
// - Unimplemented register bits read zero and ignore writes.
// - All selector fields clear at reset, so every input starts grounded.
// - Selector fields are read/write; a read returns the last written code.
// - Bits 14-8 of encoder1_home_index_sel choose encoder A home source.
// - Bits 6-0 of encoder1_home_index_sel choose encoder A index source.
// - Bits 14-8 of encoder2_phase_sel choose encoder B phase B source.
// - Bits 6-0 of encoder2_phase_sel choose encoder B phase A source.
// - Bits 14-8 of encoder2_home_index_sel choose encoder B home source.
// - Bits 6-0 of encoder2_home_index_sel choose encoder B index source.
// - Bits 6-0 of uart_one_receive_sel choose UART one receive source.
// - Bits 6-0 of uart_two_receive_sel choose UART two receive source.
// - Bits 14-8 of spi_two_clock_data_sel choose SPI two clock source.
// - Bits 6-0 of spi_two_clock_data_sel choose SPI two data-in source.
// - Bits 6-0 of spi_two_slave_select_sel choose SPI two select source.
// - Bits 14-8 of codec_clock_data_sel choose codec interface clock source.
// - Bits 6-0 of codec_clock_data_sel choose codec interface data-in source.
`default_nettype none
package rmsel_pkg;
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam int SEL_W = 7;
    localparam int NUM_REGS = 8;
    localparam int IDX_W = 3;
    localparam int NUM_PINS = 128;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 4;
    localparam int LO_LSB = 0;
    localparam int HI_LSB = 8;
    localparam int STRB_LO = 0;
    localparam int STRB_HI = 1;
    localparam logic [AXI_ADDR_W-1:0] OFF_ENC1_HOME_INDEX = 8'h00;
    localparam logic [AXI_ADDR_W-1:0] OFF_ENC2_PHASE = 8'h04;
    localparam logic [AXI_ADDR_W-1:0] OFF_ENC2_HOME_INDEX = 8'h08;
    localparam logic [AXI_ADDR_W-1:0] OFF_UART_ONE_RX = 8'h0c;
    localparam logic [AXI_ADDR_W-1:0] OFF_UART_TWO_RX = 8'h10;
    localparam logic [AXI_ADDR_W-1:0] OFF_SPI_TWO_CLK_DATA = 8'h14;
    localparam logic [AXI_ADDR_W-1:0] OFF_SPI_TWO_SELECT = 8'h18;
    localparam logic [AXI_ADDR_W-1:0] OFF_CODEC_CLK_DATA = 8'h1c;
    localparam logic [AXI_ADDR_W-1:0] MAP_MASK = 8'he0;
    localparam logic [IDX_W-1:0] IX_ENC1_HI = 3'h0;
    localparam logic [IDX_W-1:0] IX_ENC2_PH = 3'h1;
    localparam logic [IDX_W-1:0] IX_ENC2_HI = 3'h2;
    localparam logic [IDX_W-1:0] IX_UART1 = 3'h3;
    localparam logic [IDX_W-1:0] IX_UART2 = 3'h4;
    localparam logic [IDX_W-1:0] IX_SPI_CD = 3'h5;
    localparam logic [IDX_W-1:0] IX_SPI_SS = 3'h6;
    localparam logic [IDX_W-1:0] IX_CODEC = 3'h7;
    localparam logic [NUM_REGS-1:0] HAS_HI = 8'ha7;
    localparam logic [NUM_REGS-1:0] WIDE_REGS = 8'h02;
    localparam logic [SEL_W-1:0] CODE_GROUND = 7'h00;
    localparam logic [SEL_W-1:0] CODE_CMP = 7'h01;
    localparam logic [SEL_W-1:0] CODE_MAX_INPUT = 7'h7c;
    localparam logic [SEL_W-1:0] CODE_MAX_BIDIR = 7'h7f;
    localparam logic [SEL_W-1:0] SEL_RESET = 7'h00;
    localparam logic [NUM_PINS-1:0] PIN_PRESENT = {4{32'hffffffff}};
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef logic [SEL_W-1:0] rmsel_code_t;

    typedef struct packed {
        logic encoder_a_home;
        logic encoder_a_index;
        logic encoder_b_phase_a;
        logic encoder_b_phase_b;
        logic encoder_b_home;
        logic encoder_b_index;
        logic uart_one_rx;
        logic uart_two_rx;
        logic spi_two_clock;
        logic spi_two_data_in;
        logic spi_two_select;
        logic codec_clock;
        logic codec_data_in;
    } rmsel_periph_t;
endpackage
`default_nettype wire

// *** rtl/rmsel_bank.sv ***
// Selector register bank on AXI4-Lite with registered input multiplexers.
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rmsel_bank (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic awvalid,
    output logic awready,
    input wire logic [rmsel_pkg::AXI_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // Write data channel
    input wire logic wvalid,
    output logic wready,
    input wire logic [rmsel_pkg::AXI_DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    // Write response channel
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // Read address channel
    input wire logic arvalid,
    output logic arready,
    input wire logic [rmsel_pkg::AXI_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // Read data channel
    output logic rvalid,
    input wire logic rready,
    output logic [rmsel_pkg::AXI_DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // Signal sources
    input wire logic [rmsel_pkg::NUM_PINS-1:0] remap_pin,
    input wire logic comparator_one_output,
    // Routed peripheral inputs
    output rmsel_pkg::rmsel_periph_t periph
);
    import rmsel_pkg::*;

    // Selector storage, one low and one high field per register.
    rmsel_code_t lo_reg [NUM_REGS];
    rmsel_code_t lo_next [NUM_REGS];
    rmsel_code_t hi_reg [NUM_REGS];
    rmsel_code_t hi_next [NUM_REGS];

    // Bus state.
    logic aw_full_reg;
    logic aw_full_next;
    logic w_full_reg;
    logic w_full_next;
    logic [AXI_ADDR_W-1:0] aw_addr_reg;
    logic [AXI_ADDR_W-1:0] aw_addr_next;
    logic [AXI_DATA_W-1:0] w_data_reg;
    logic [AXI_DATA_W-1:0] w_data_next;
    logic [3:0] w_strb_reg;
    logic [3:0] w_strb_next;
    logic awready_reg;
    logic awready_next;
    logic wready_reg;
    logic wready_next;
    logic bvalid_reg;
    logic bvalid_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;
    logic arready_reg;
    logic arready_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic [AXI_DATA_W-1:0] rdata_reg;
    logic [AXI_DATA_W-1:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;
    rmsel_periph_t periph_reg;
    rmsel_periph_t periph_next;

    logic do_write;
    logic [IDX_W-1:0] w_idx;

    // A register offset is mapped when no bit above the index is set.
    function automatic logic addr_mapped(input logic [AXI_ADDR_W-1:0] addr);
        return (addr & MAP_MASK) == OFF_ENC1_HOME_INDEX;
    endfunction

    function automatic logic [IDX_W-1:0] addr_index(input logic [AXI_ADDR_W-1:0] addr);
        return addr[IDX_MSB:IDX_LSB];
    endfunction

    // One source multiplexer. Codes above the selector's ceiling or
    // naming a pin the package lacks come out low rather than floating.
    function automatic logic route_src(
        input rmsel_code_t code,
        input rmsel_code_t max_code,
        input logic [NUM_PINS-1:0] pins,
        input logic cmp
    );
        logic v;
        v = 1'b0;
        if (code == CODE_GROUND)
        begin
            v = 1'b0;
        end
        else if (code == CODE_CMP)
        begin
            v = cmp;
        end
        else if (code <= max_code)
        begin
            v = pins[code] & PIN_PRESENT[code];
        end
        return v;
    endfunction

    // Unimplemented bits 31-15 and 7 read zero; the high field of a
    // single-field register reads zero as well.
    function automatic logic [AXI_DATA_W-1:0] read_word(
        input rmsel_code_t lo,
        input rmsel_code_t hi,
        input logic has_hi
    );
        logic [AXI_DATA_W-1:0] w;
        w = '0;
        w[LO_LSB +: SEL_W] = lo;
        if (has_hi)
        begin
            w[HI_LSB +: SEL_W] = hi;
        end
        return w;
    endfunction

    function automatic rmsel_code_t ceiling(input logic [IDX_W-1:0] idx);
        return WIDE_REGS[idx] ? CODE_MAX_BIDIR : CODE_MAX_INPUT;
    endfunction

    assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    assign w_idx = addr_index(aw_addr_reg);

    // Write path: address and data are caught in either order, the
    // write lands once both are held and no response is pending.
    always_comb
    begin
        aw_full_next = aw_full_reg;
        w_full_next = w_full_reg;
        aw_addr_next = aw_addr_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        for (int i = 0; i < NUM_REGS; i++)
        begin
            lo_next[i] = lo_reg[i];
            hi_next[i] = hi_reg[i];
        end
        if (awvalid && awready_reg)
        begin
            aw_full_next = 1'b1;
            aw_addr_next = awaddr;
        end
        if (wvalid && wready_reg)
        begin
            w_full_next = 1'b1;
            w_data_next = wdata;
            w_strb_next = wstrb;
        end
        if (do_write)
        begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_SLVERR;
            if (addr_mapped(aw_addr_reg))
            begin
                bresp_next = RESP_OKAY;
                if (w_strb_reg[STRB_LO])
                begin
                    lo_next[w_idx] = w_data_reg[LO_LSB +: SEL_W];
                end
                if (w_strb_reg[STRB_HI] && HAS_HI[w_idx])
                begin
                    hi_next[w_idx] = w_data_reg[HI_LSB +: SEL_W];
                end
            end
        end
        else if (bvalid_reg && bready)
        begin
            bvalid_next = 1'b0;
        end
        awready_next = !aw_full_next && !bvalid_next;
        wready_next = !w_full_next && !bvalid_next;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            for (int i = 0; i < NUM_REGS; i++)
            begin
                lo_reg[i] <= SEL_RESET;
                hi_reg[i] <= SEL_RESET;
            end
        end
        else
        begin
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            aw_addr_reg <= aw_addr_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            for (int i = 0; i < NUM_REGS; i++)
            begin
                lo_reg[i] <= lo_next[i];
                hi_reg[i] <= hi_next[i];
            end
        end
    end

    // Read path: the word is captured on the address handshake, so a
    // write landing one cycle later does not disturb the answer.
    always_comb
    begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (arvalid && arready_reg)
        begin
            rvalid_next = 1'b1;
            rdata_next = '0;
            rresp_next = RESP_SLVERR;
            if (addr_mapped(araddr))
            begin
                rresp_next = RESP_OKAY;
                rdata_next = read_word(lo_reg[addr_index(araddr)],
                    hi_reg[addr_index(araddr)], HAS_HI[addr_index(araddr)]);
            end
        end
        else if (rvalid_reg && rready)
        begin
            rvalid_next = 1'b0;
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
            arready_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            arready_reg <= arready_next;
        end
    end

    // Routing: every peripheral input is re-evaluated each cycle from the
    // current selector, registered once so the peripherals see clean levels.
    always_comb
    begin
        periph_next.encoder_a_home = route_src(hi_reg[IX_ENC1_HI],
            ceiling(IX_ENC1_HI), remap_pin, comparator_one_output);
        periph_next.encoder_a_index = route_src(lo_reg[IX_ENC1_HI],
            ceiling(IX_ENC1_HI), remap_pin, comparator_one_output);
        periph_next.encoder_b_phase_b = route_src(hi_reg[IX_ENC2_PH],
            ceiling(IX_ENC2_PH), remap_pin, comparator_one_output);
        periph_next.encoder_b_phase_a = route_src(lo_reg[IX_ENC2_PH],
            ceiling(IX_ENC2_PH), remap_pin, comparator_one_output);
        periph_next.encoder_b_home = route_src(hi_reg[IX_ENC2_HI],
            ceiling(IX_ENC2_HI), remap_pin, comparator_one_output);
        periph_next.encoder_b_index = route_src(lo_reg[IX_ENC2_HI],
            ceiling(IX_ENC2_HI), remap_pin, comparator_one_output);
        periph_next.uart_one_rx = route_src(lo_reg[IX_UART1],
            ceiling(IX_UART1), remap_pin, comparator_one_output);
        periph_next.uart_two_rx = route_src(lo_reg[IX_UART2],
            ceiling(IX_UART2), remap_pin, comparator_one_output);
        periph_next.spi_two_clock = route_src(hi_reg[IX_SPI_CD],
            ceiling(IX_SPI_CD), remap_pin, comparator_one_output);
        periph_next.spi_two_data_in = route_src(lo_reg[IX_SPI_CD],
            ceiling(IX_SPI_CD), remap_pin, comparator_one_output);
        periph_next.spi_two_select = route_src(lo_reg[IX_SPI_SS],
            ceiling(IX_SPI_SS), remap_pin, comparator_one_output);
        periph_next.codec_clock = route_src(hi_reg[IX_CODEC],
            ceiling(IX_CODEC), remap_pin, comparator_one_output);
        periph_next.codec_data_in = route_src(lo_reg[IX_CODEC],
            ceiling(IX_CODEC), remap_pin, comparator_one_output);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            periph_reg <= '0;
        end
        else
        begin
            periph_reg <= periph_next;
        end
    end

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign periph = periph_reg;
endmodule
`default_nettype wire

// *** bench/rmsel_periph_model.sv ***
// Peripheral side model that latches the routed inputs as the consumers would.
`timescale 1ns/1ps
`default_nettype none
module rmsel_periph_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Routed inputs and their latched copy
    input wire rmsel_pkg::rmsel_periph_t periph,
    output rmsel_pkg::rmsel_periph_t seen
);
    import rmsel_pkg::*;
    // Consumers sample synchronously, so a glitch inside one cycle is never seen.
    always_ff @(posedge aclk)
    begin
        seen <= aresetn ? periph : '0;
    end
endmodule
`default_nettype wire

// *** bench/rmsel_bank_props.sv ***
// Concurrent checks on the selector bank's bus and output ports.
`timescale 1ns/1ps
`default_nettype none
module rmsel_bank_props (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [rmsel_pkg::AXI_ADDR_W-1:0] araddr,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [rmsel_pkg::AXI_DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    // Routed outputs
    input wire rmsel_pkg::rmsel_periph_t periph
);
    import rmsel_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    sequence both_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence write_done;
        bvalid && bready;
    endsequence
    sequence read_taken;
        arvalid && arready;
    endsequence
    chk_reset_clear: assert property (!aresetn |=> periph == '0 && !bvalid && !rvalid)
        else $error("outputs not cleared by reset");
    chk_ready_open: assert property (disable iff (!aresetn) $rose(aresetn) |=> awready && arready)
        else $error("readies not open after reset");
    chk_write_answer: assert property (disable iff (!aresetn) both_taken |-> ##2 bvalid)
        else $error("write response late");
    chk_write_hold: assert property (disable iff (!aresetn) bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    chk_write_reopen: assert property (disable iff (!aresetn) write_done |=> awready && wready)
        else $error("write channels not reopened");
    chk_read_answer: assert property (disable iff (!aresetn) read_taken |=> rvalid && !arready)
        else $error("read answer late");
    chk_read_hold: assert property (disable iff (!aresetn) rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    chk_unused_bits: assert property (disable iff (!aresetn) rvalid |-> rdata[31:15] == '0 && !rdata[7])
        else $error("unimplemented bits read nonzero");
    chk_unmapped_read: assert property (disable iff (!aresetn) read_taken ##0 araddr[7:5] != 3'h0 |=> rresp == RESP_SLVERR && rdata == '0)
        else $error("unmapped read not refused");
    chk_mapped_read: assert property (disable iff (!aresetn) read_taken ##0 araddr[7:5] == 3'h0 |=> rresp == RESP_OKAY)
        else $error("mapped read refused");
endmodule
`default_nettype wire

// *** bench/tb_remappable_input_select_bank.sv ***
// Self-checking bench for the selector bank with a behavioural register model.
`timescale 1ns/1ps
`default_nettype none
module tb_remappable_input_select_bank;
    import rmsel_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, comparator_one_output = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rnd = 32'h63bb0876, d;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp, r;
    logic [NUM_PINS-1:0] remap_pin = '0;
    rmsel_periph_t periph, seen;
    int mismatches = 0, samples_checked = 0, mlo[8], mhi[8], codes[9], lo, hi;
    always #4 aclk = ~aclk;
    rmsel_bank i_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .remap_pin(remap_pin),
        .comparator_one_output(comparator_one_output), .periph(periph));
    rmsel_periph_model i_model (.aclk(aclk), .aresetn(aresetn), .periph(periph), .seen(seen));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
    endfunction
    function automatic logic route(input int code, input bit wide);
        if (code == 0) return 1'b0;
        if (code == 1) return comparator_one_output;
        if (code <= 124 || wide) return remap_pin[code];
        return 1'b0;
    endfunction
    function automatic rmsel_periph_t expect_periph();
        rmsel_periph_t p;
        p = {route(mhi[0], 0), route(mlo[0], 0), route(mlo[1], 1), route(mhi[1], 1),
            route(mhi[2], 0), route(mlo[2], 0), route(mlo[3], 0), route(mlo[4], 0),
            route(mhi[5], 0), route(mlo[5], 0), route(mlo[6], 0), route(mhi[7], 0),
            route(mlo[7], 0)};
        return p;
    endfunction
    task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
        samples_checked++;
        if (seen_v !== exp_v)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        int n;
        n = rnd[2:0];
        rnd = lfsr(rnd);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1;
        wvalid <= 1;
        // A late bready keeps the response standing, so its hold gets exercised.
        bready <= (n == 0);
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (n > 0) n--;
            if (n == 0 && !bready) bready <= 1;
        end
        while (!(bvalid && bready));
        r = bresp;
        bready <= 0;
    endtask
    task automatic axi_read(input logic [7:0] a);
        int n;
        n = rnd[2:0];
        rnd = lfsr(rnd);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= (n == 0);
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (n > 0) n--;
            if (n == 0 && !rready) rready <= 1;
        end
        while (!(rvalid && rready));
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask
    task automatic read_all();
        for (int i = 0; i < NUM_REGS; i++)
        begin
            axi_read(8'(i * 4));
            check(d, (mhi[i] << 8) | mlo[i]);
        end
    endtask
    task automatic pins_check();
        repeat (4)
        begin
            @(posedge aclk);
            remap_pin <= {rnd, ~rnd, rnd ^ 32'h5a5a5a5a, lfsr(rnd)};
            comparator_one_output <= rnd[3];
            rnd = lfsr(lfsr(rnd));
            repeat (3) @(posedge aclk);
            @(negedge aclk);
            check(32'(periph), 32'(expect_periph()));
            check(32'(seen), 32'(expect_periph()));
        end
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #200000;
        mismatches++;
        complete_run();
    end
    initial
    begin
        codes = '{0, 1, 2, 85, 124, 125, 126, 127, 3};
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        read_all();
        pins_check();
        $display("Test reset state done");
        for (int t = 0; t < 9; t++)
        begin
            for (int i = 0; i < NUM_REGS; i++)
            begin
                lo = codes[t];
                hi = codes[(t + i) % 9];
                axi_write(8'(i * 4), {rnd[31:15], 7'(hi), rnd[7], 7'(lo)}, 4'hf);
                check(32'(r), 32'(RESP_OKAY));
                mlo[i] = lo;
                mhi[i] = HAS_HI[i] ? hi : 0;
                rnd = lfsr(rnd);
            end
            read_all();
            pins_check();
        end
        $display("Test code table done");
        // Only the high lane is strobed, so the low field must keep its code.
        axi_write(OFF_ENC2_PHASE, 32'h00003c11, 4'h2);
        check(32'(r), 32'(RESP_OKAY));
        mhi[1] = 8'h3c;
        axi_write(OFF_UART_ONE_RX, 32'h00007f05, 4'h2);
        check(32'(r), 32'(RESP_OKAY));
        read_all();
        $display("Test strobe lanes done");
        axi_write(8'h20, 32'h00007f7f, 4'hf);
        check(32'(r), 32'(RESP_SLVERR));
        axi_read(8'he4);
        check(32'(r), 32'(RESP_SLVERR));
        check(d, 32'h0);
        read_all();
        pins_check();
        $display("Test unmapped access done");
        // A reset in mid-run must clear codes that software has written.
        @(posedge aclk);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        for (int i = 0; i < NUM_REGS; i++)
        begin
            mlo[i] = 0;
            mhi[i] = 0;
        end
        repeat (2) @(posedge aclk);
        read_all();
        pins_check();
        $display("Test mid-run reset done");
        complete_run();
    end
endmodule
bind rmsel_bank rmsel_bank_props i_props (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .periph(periph));
`default_nettype wire
